// file: hdl/lqmc_regs.vh
`ifndef LQMC_REGS_VH
`define LQMC_REGS_VH

// word indices; byte address is four times the index
`define LQMC_IDX_QM          6'h1d
`define LQMC_IDX_THR_BASE    6'h20
`define LQMC_IDX_THR_LAST    6'h29
`define LQMC_IDX_CTRL        6'h2a
`define LQMC_IDX_IRQ_STAT    6'h2b
`define LQMC_IDX_IRQ_MASK    6'h2c

// quality monitor register fields
`define LQMC_QM_RESET        16'h0000
`define LQMC_QM_ENABLE_BIT   15
`define LQMC_QM_RESTART_HI   14
`define LQMC_QM_RESTART_LO   10
`define LQMC_QM_WARN_HI      9
`define LQMC_QM_WARN_LO      0
`define LQMC_QM_RW_MASK      16'hfc00

// warning bit pairs, {high, low} per parameter
`define LQMC_P_EQ            0
`define LQMC_P_GAIN          1
`define LQMC_P_BW            2
`define LQMC_P_FO            3
`define LQMC_P_FC            4
`define LQMC_NUM_PARAMS      5

// pcs control mirror, signal detect option position
`define LQMC_CTRL_SD_BIT     8
`define LQMC_CTRL_RESET      16'h0000

// interrupt status and mask, one event bit
`define LQMC_IRQ_LQ_BIT      0
`define LQMC_IRQ_RESET       1'b0

// threshold select values: 0 picks the low threshold, 1 the high one
`define LQMC_THR_SEL_LOW     1'b0
`define LQMC_THR_SEL_HIGH    1'b1

`endif

// file: hdl/lqmc_ctrl.v
// What this block does
// - checking runs only with enable bit 15 set and a valid 100 Mb link.
// - a violation while armed raises the interrupt only when the mask enables it.
// - reading the monitor register clears all warnings not hit in that cycle and re-arms the interrupt.
// - bit 14 set: frequency control violation resets processor, restarts adaption.
// - bit 13 set: frequency offset violation resets processor, restarts adaption.
// - bit 12 set: baseline wander violation resets processor, restarts adaption.
// - bit 11 set: gain control violation resets processor, restarts adaption.
// - bit 10 set: equalizer coefficient violation resets processor, restarts adaption.
// - restart-enabled violation with signal detect option 0 also drops link.
// - bit 9 frequency control high, bit 8 low; read only, clear on read.
// - bit 7 frequency offset high, bit 6 low; read only, clear on read.
// - bit 5 baseline wander high, bit 4 low; read only, clear on read.
// - bit 3 gain control high, bit 2 low; read only, clear on read.
// - bit 1 equalizer coefficient high, bit 0 low; read only, clear on read.
// - threshold select 0 picks the low threshold, 1 the high threshold.
`include "lqmc_regs.vh"
`default_nettype none

module lqmc_ctrl #(
    parameter PW = 16
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [7:0]    wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output wire [31:0]   wb_dat_o,
    output wire          wb_ack_o,
    input  wire          link_100_valid_i,
    input  wire [PW-1:0] freq_control_i,
    input  wire [PW-1:0] freq_offset_i,
    input  wire [PW-1:0] baseline_wander_param_i,
    input  wire [PW-1:0] digital_gain_param_i,
    input  wire [PW-1:0] equalizer_first_coeff_i,
    output wire          dsp_reset_o,
    output wire          adapt_restart_o,
    output wire          link_drop_o,
    output wire          irq_o
);

    localparam NP = `LQMC_NUM_PARAMS;
    localparam [PW-1:0] THR_MAX = {1'b0, {(PW-1){1'b1}}};
    localparam [PW-1:0] THR_MIN = {1'b1, {(PW-1){1'b0}}};

    // ---------------- bus slave ----------------
    reg         ack_r;
    reg  [31:0] rdata_r;
    wire        req     = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        wr      = req & wb_we_i;
    wire        rd      = req & ~wb_we_i;
    wire [5:0]  idx     = wb_adr_i[7:2];

    // byte lanes of the 16-bit registers
    wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // ---------------- control and state ----------------
    reg  [5:0]  qm_ctrl_r;      // enable plus five restart bits
    wire [9:0]  warn_q;
    reg  [15:0] pcs_ctrl_r;
    reg         irq_stat_r;
    reg         irq_mask_r;
    reg         armed_r;
    reg  [9:0]  viol_d_r;
    reg         dsp_reset_r;
    reg         adapt_restart_r;
    reg         link_drop_r;

    reg  [PW-1:0] thr_lo_r [0:NP-1];
    reg  [PW-1:0] thr_hi_r [0:NP-1];

    wire        mon_enable     = qm_ctrl_r[5];
    wire [4:0]  restart_en     = qm_ctrl_r[4:0];
    wire        signal_detect_option      = pcs_ctrl_r[`LQMC_CTRL_SD_BIT];

    wire [15:0] qm_word = {qm_ctrl_r, warn_q};

    // live parameters packed with the warning order: fc, fo, bw, gain, eq
    wire [NP*PW-1:0] params = {freq_control_i, freq_offset_i, baseline_wander_param_i,
                               digital_gain_param_i, equalizer_first_coeff_i};

    wire active = mon_enable & link_100_valid_i;

    // ---------------- threshold compare ----------------
    wire [9:0] viol;
    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : g_cmp
            lqmc_thr_cmp #(
                .PW (PW)
            ) cmp_u (
                .active_i  (active),
                .param_i   (params[g*PW +: PW]),
                .thr_lo_i  (thr_lo_r[g]),
                .thr_hi_i  (thr_hi_r[g]),
                .viol_hi_o (viol[2*g+1]),
                .viol_lo_o (viol[2*g])
            );
        end
    endgenerate

    // only fresh crossings count, so a standing fault does not loop restarts
    wire [9:0] viol_new = viol & ~viol_d_r;

    wire [4:0] param_hit;
    generate
        for (g = 0; g < NP; g = g + 1) begin : g_hit
            assign param_hit[g] = viol_new[2*g+1] | viol_new[2*g];
        end
    endgenerate

    wire restart_hit = |(param_hit & restart_en);

    wire qm_read = rd & (idx == `LQMC_IDX_QM);

    // ---------------- warning latches ----------------
    // one sticky latch per warning bit; a clearing read never hides a fresh hit
    generate
        for (g = 0; g < 2 * NP; g = g + 1) begin : g_warn
            lqmc_sticky warn_u (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .set_i (viol[g]),
                .clr_i (qm_read),
                .q_o   (warn_q[g])
            );
        end
    endgenerate

    // threshold register decode
    wire       thr_hit  = (idx >= `LQMC_IDX_THR_BASE) & (idx <= `LQMC_IDX_THR_LAST);
    wire [5:0] thr_off  = idx - `LQMC_IDX_THR_BASE;
    wire [2:0] thr_prm  = thr_off[3:1];
    wire       thr_sel  = thr_off[0];

    // ---------------- register writes and state ----------------
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r           <= 1'b0;
            qm_ctrl_r       <= 6'h00;
            pcs_ctrl_r      <= `LQMC_CTRL_RESET;
            irq_stat_r      <= `LQMC_IRQ_RESET;
            irq_mask_r      <= `LQMC_IRQ_RESET;
            armed_r         <= 1'b1;
            viol_d_r        <= 10'h000;
            dsp_reset_r     <= 1'b0;
            adapt_restart_r <= 1'b0;
            link_drop_r     <= 1'b0;
            for (i = 0; i < NP; i = i + 1) begin
                thr_lo_r[i] <= THR_MIN;
                thr_hi_r[i] <= THR_MAX;
            end
        end else begin
            ack_r    <= req;
            viol_d_r <= viol;

            if (wr && idx == `LQMC_IDX_QM) begin
                qm_ctrl_r <= (qm_ctrl_r & ~lane_mask[15:10]) |
                             (wb_dat_i[15:10] & lane_mask[15:10]);
            end
            if (wr && idx == `LQMC_IDX_CTRL) begin
                pcs_ctrl_r <= (pcs_ctrl_r & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
            end
            if (wr && idx == `LQMC_IDX_IRQ_MASK && wb_sel_i[0]) begin
                irq_mask_r <= wb_dat_i[`LQMC_IRQ_LQ_BIT];
            end
            if (wr && thr_hit) begin
                for (i = 0; i < NP; i = i + 1) begin
                    if (thr_prm == i[2:0]) begin
                        if (thr_sel == `LQMC_THR_SEL_HIGH) begin
                            thr_hi_r[i] <= (thr_hi_r[i] & ~lane_mask[PW-1:0]) |
                                           (wb_dat_i[PW-1:0] & lane_mask[PW-1:0]);
                        end else begin
                            thr_lo_r[i] <= (thr_lo_r[i] & ~lane_mask[PW-1:0]) |
                                           (wb_dat_i[PW-1:0] & lane_mask[PW-1:0]);
                        end
                    end
                end
            end

            // one interrupt per armed period; the read re-arms it
            if (armed_r && (|viol)) begin
                armed_r <= 1'b0;
            end else if (qm_read) begin
                armed_r <= 1'b1;
            end

            // event set wins over a one-written clear in the same cycle
            if (armed_r && (|viol)) begin
                irq_stat_r <= 1'b1;
            end else if (wr && idx == `LQMC_IDX_IRQ_STAT && wb_sel_i[0] &&
                         wb_dat_i[`LQMC_IRQ_LQ_BIT]) begin
                irq_stat_r <= 1'b0;
            end

            dsp_reset_r     <= restart_hit;
            adapt_restart_r <= restart_hit;
            link_drop_r     <= restart_hit & ~signal_detect_option;
        end
    end

    // ---------------- read data ----------------
    // own loop index, so the clocked block's index has one driver
    integer j;
    reg [15:0] rd_word;
    always @* begin
        rd_word = 16'h0000;
        if (idx == `LQMC_IDX_QM) begin
            rd_word = qm_word;
        end else if (idx == `LQMC_IDX_CTRL) begin
            rd_word = pcs_ctrl_r;
        end else if (idx == `LQMC_IDX_IRQ_STAT) begin
            rd_word = {15'h0000, irq_stat_r};
        end else if (idx == `LQMC_IDX_IRQ_MASK) begin
            rd_word = {15'h0000, irq_mask_r};
        end else if (thr_hit) begin
            for (j = 0; j < NP; j = j + 1) begin
                if (thr_prm == j[2:0]) begin
                    rd_word = 16'h0000;
                    if (thr_sel == `LQMC_THR_SEL_HIGH) begin
                        rd_word[PW-1:0] = thr_hi_r[j];
                    end else begin
                        rd_word[PW-1:0] = thr_lo_r[j];
                    end
                end
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd) begin
            rdata_r <= {16'h0000, rd_word};
        end
    end

    assign wb_dat_o        = rdata_r;
    assign wb_ack_o        = ack_r;
    assign irq_o           = irq_stat_r & irq_mask_r;
    assign dsp_reset_o     = dsp_reset_r;
    assign adapt_restart_o = adapt_restart_r;
    assign link_drop_o     = link_drop_r;

endmodule // lqmc_ctrl

module lqmc_thr_cmp #(
    parameter PW = 16
) (
    input  wire          active_i,
    input  wire [PW-1:0] param_i,
    input  wire [PW-1:0] thr_lo_i,
    input  wire [PW-1:0] thr_hi_i,
    output wire          viol_hi_o,
    output wire          viol_lo_o
);
    // parameters and thresholds are two's complement
    wire signed [PW-1:0] pv = param_i;
    wire signed [PW-1:0] lo = thr_lo_i;
    wire signed [PW-1:0] hi = thr_hi_i;

    // a threshold at the range end can never be crossed
    assign viol_hi_o = active_i & (pv > hi);
    assign viol_lo_o = active_i & (pv < lo);

endmodule // lqmc_thr_cmp

module lqmc_sticky (
    input  wire clk_i,
    input  wire rst_i,
    input  wire set_i,
    input  wire clr_i,
    output wire q_o
);
    reg q_r;

    // set wins over a clear in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= 1'b0;
        end else if (set_i) begin
            q_r <= 1'b1;
        end else if (clr_i) begin
            q_r <= 1'b0;
        end
    end

    assign q_o = q_r;

endmodule // lqmc_sticky

`default_nettype wire

// file: verification/lqmc_ctrl_sva.sv
`default_nettype none

module lqmc_ctrl_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        link_100_valid_i,
    input wire logic        dsp_reset_o,
    input wire logic        adapt_restart_o,
    input wire logic        link_drop_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_dat_hold: assert property (wb_ack_o |=> $stable(wb_dat_o))
        else $error("read data moved after ack");
    chk_dat_upper: assert property (wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    chk_restart_pair: assert property (dsp_reset_o == adapt_restart_o)
        else $error("reset and restart pulses differ");
    chk_drop_pair: assert property (link_drop_o |-> dsp_reset_o)
        else $error("link drop without processor reset");
    chk_link_gate: assert property (!link_100_valid_i |=> !dsp_reset_o)
        else $error("restart without valid link");
endmodule // lqmc_ctrl_sva

bind lqmc_ctrl lqmc_ctrl_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .link_100_valid_i(link_100_valid_i), .dsp_reset_o(dsp_reset_o),
    .adapt_restart_o(adapt_restart_o), .link_drop_o(link_drop_o));

`default_nettype wire

// file: verification/lqmc_ctrl_tb.sv
`include "lqmc_regs.vh"
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end

module lqmc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] QM = {`LQMC_IDX_QM, 2'b00};
    localparam logic [7:0] CT = {`LQMC_IDX_CTRL, 2'b00};
    localparam logic [7:0] ST = {`LQMC_IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] MK = {`LQMC_IDX_IRQ_MASK, 2'b00};
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, link = 0;
    logic [7:0]  adr = 0;
    logic [31:0] wd = 0, q;
    logic [15:0] par [5] = '{default: 16'h0000};
    wire  [31:0] dat;
    wire         ack, dsp, ar, drop, irq;
    int          n_fail = 0, compares = 0, nrst = 0, ndrop = 0;

    lqmc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat),
        .wb_ack_o(ack), .link_100_valid_i(link), .freq_control_i(par[4]),
        .freq_offset_i(par[3]), .baseline_wander_param_i(par[2]),
        .digital_gain_param_i(par[1]), .equalizer_first_coeff_i(par[0]),
        .dsp_reset_o(dsp), .adapt_restart_o(ar), .link_drop_o(drop), .irq_o(irq));

    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        nrst += int'(dsp & ar);
        ndrop += int'(drop);
    end

    task final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wd <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            final_report;
        end
        q = dat;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask

    task rchk(input logic [7:0] a, input logic [15:0] e);
        xfer(0, a, 0);
        `CHK(q, {16'h0000, e})
    endtask

    // one cycle of violation, then settle so pulses and irq have landed
    task viol(input int p, input logic [15:0] v);
        @(posedge clk_i);
        par[p] <= v;
        @(posedge clk_i);
        par[p] <= 16'h0000;
        repeat (2) @(posedge clk_i);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        rchk(QM, 16'h0000);
        rchk(CT, 16'h0000);
        rchk(ST, 16'h0000);
        rchk(MK, 16'h0000);
        rchk(8'hfc, 16'h0000);
        xfer(1, QM, 32'h0000ffff);
        rchk(QM, 16'hfc00);
        xfer(1, MK, 32'h1);
        link <= 1;
        $display("test reset_values done");
        for (int p = 0; p < 5; p++) begin
            xfer(1, 8'h80 + 8'(8 * p), 32'h0000fff6);
            xfer(1, 8'h84 + 8'(8 * p), 32'h0000000a);
            for (int s = 0; s < 2; s++) begin
                viol(p, s ? 16'h000a : 16'hfff6);
                rchk(QM, 16'hfc00);
                viol(p, s ? 16'h000b : 16'hfff5);
                `CHK(irq, 1'b1)
                rchk(QM, 16'hfc00 | (16'h1 << (2 * p + s)));
                rchk(QM, 16'hfc00);
                xfer(1, ST, 32'h1);
                `CHK(irq, 1'b0)
            end
        end
        `CHK(nrst, 10)
        `CHK(ndrop, 10)
        $display("test thresholds done");
        xfer(1, CT, 32'h00000100);
        viol(0, 16'hfff5);
        xfer(1, ST, 32'h1);
        viol(0, 16'hfff5);
        `CHK(irq, 1'b0)
        rchk(QM, 16'hfc01);
        `CHK(nrst, 12)
        `CHK(ndrop, 10)
        $display("test rearm done");
        link <= 0;
        viol(4, 16'h000b);
        rchk(QM, 16'hfc00);
        link <= 1;
        xfer(1, QM, 32'h00008000);
        viol(4, 16'h000b);
        rchk(QM, 16'h8200);
        `CHK(nrst, 12)
        xfer(1, MK, 32'h0);
        `CHK(irq, 1'b0)
        xfer(1, 8'ha4, 32'h00007fff);
        xfer(1, 8'ha0, 32'h00008000);
        viol(4, 16'h7fff);
        viol(4, 16'h8000);
        rchk(QM, 16'h8000);
        xfer(1, QM, 32'h00000000);
        viol(4, 16'h000b);
        rchk(QM, 16'h0000);
        $display("test gating done");
        final_report;
    end

    initial begin
        #(4 * 5000);
        n_fail++;
        final_report;
    end
endmodule // lqmc_ctrl_tb

`default_nettype wire
